// [design/pss_defines.vh]
// Purpose: constants for the passive serial configuration slave
// Assumes: 25 MHz system clock
// Notes:   times are kept in their own units, counts derived below
//
// Notes on behaviour
// - Fast option holds power-on reset longer than 3 ms, under 9 ms.
// - Standard option holds power-on reset longer than 50 ms, under 200 ms.
// - During power-on reset, status line driven low and user pins high-Z.
// - User pins stay high-Z until configuration and initialization finish.
// - Device stays in reset while request or status line is low.
// - On request rising, device leaves reset and releases status line.
// - Device samples data on each rising edge of the bit clock.
// - After whole error-free bitstream, device releases load-complete line.
// - Device accepts a compressed bitstream and expands it while loading.
// - On error drive status low; with auto restart release within 230 us.
// - Request low in user mode pulls status and load-complete low, pins high-Z.
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// ==========================================================
// Timing
`define PSS_CLK_MHZ         25
`define PSS_POR_FAST_MIN_US 3000
`define PSS_POR_STD_MIN_US  50000
`define PSS_RESTART_MAX_US  230
`define PSS_POR_FAST_CYC    (`PSS_POR_FAST_MIN_US * `PSS_CLK_MHZ + 1)
`define PSS_POR_STD_CYC     (`PSS_POR_STD_MIN_US * `PSS_CLK_MHZ + 1)
`define PSS_RESTART_CYC     (`PSS_RESTART_MAX_US * `PSS_CLK_MHZ)
`define PSS_CNT_W           21

// ==========================================================
// Scheme select straps
`define PSS_SCHEME_STD      4'h0
`define PSS_SCHEME_FAST     4'hc

// ==========================================================
// Reset values
`define PSS_RST_OE_N        1'b0
`define PSS_RST_HIZ         1'b1

`endif

// [design/pss_config_slave.v]
// Purpose: passive serial configuration slave, device side
// Assumes: bit clock and data are slow against CLOCK (>= 4 cycles/bit)
// Notes:   open-drain lines use out/oe_n pairs, oe_n low drives low
`timescale 1ns/100ps
`include "pss_defines.vh"

module pss_config_slave #(
  parameter [20:0] POR_FAST_CYCLES = `PSS_POR_FAST_CYC,
  parameter [20:0] POR_STD_CYCLES  = `PSS_POR_STD_CYC,
  parameter [20:0] RESTART_CYCLES  = `PSS_RESTART_CYC,
  parameter        WIDTH           = 8,
  parameter        DEPTH           = 2,
  parameter        AW              = 1,
  parameter        LEN_W           = 24
) (
  input  wire             CLOCK,
  input  wire             RSTN,
  input  wire [3:0]       SCHEME_SELECT,
  input  wire             CFG_REQUEST_N,
  input  wire             CFG_ERROR_RESET_N_IN,
  output wire             CFG_ERROR_RESET_N_OUT,
  output reg              CFG_ERROR_RESET_N_OE_N,
  input  wire             LOAD_COMPLETE_IN,
  output wire             LOAD_COMPLETE_OUT,
  output reg              LOAD_COMPLETE_OE_N,
  input  wire             CFG_BIT_CLOCK,
  input  wire             CFG_DATA,
  input  wire             AUTO_RESTART,
  input  wire             COMPRESSED,
  input  wire [LEN_W-1:0] LOAD_LENGTH,
  input  wire             INIT_DONE,
  output reg              USER_IO_HIZ,
  output reg              CFG_ERROR,
  output wire [WIDTH-1:0] CFG_BYTE,
  output wire             CFG_BYTE_VALID,
  input  wire             CFG_BYTE_READY
);

  localparam [2:0] ST_POR    = 3'h0;
  localparam [2:0] ST_RESET  = 3'h1;
  localparam [2:0] ST_CONFIG = 3'h2;
  localparam [2:0] ST_ERROR  = 3'h3;
  localparam [2:0] ST_DONE   = 3'h4;
  localparam [2:0] ST_USER   = 3'h5;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1)
        ptr_inc = {AW{1'b0}};
      else
        ptr_inc = p + 1'b1;
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  reg [1:0] req_q;
  reg [1:0] err_q;
  reg [1:0] done_q;
  reg [2:0] bclk_q;
  reg [1:0] bdat_q;
  reg [3:0] sel_q0;
  reg [3:0] sel_q1;

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      req_q  <= 2'h0;
      err_q  <= 2'h0;
      done_q <= 2'h0;
      bclk_q <= 3'h0;
      bdat_q <= 2'h0;
      sel_q0 <= 4'h0;
      sel_q1 <= 4'h0;
    end else begin
      req_q  <= {req_q[0], CFG_REQUEST_N};
      err_q  <= {err_q[0], CFG_ERROR_RESET_N_IN};
      done_q <= {done_q[0], LOAD_COMPLETE_IN};
      bclk_q <= {bclk_q[1:0], CFG_BIT_CLOCK};
      bdat_q <= {bdat_q[0], CFG_DATA};
      sel_q0 <= SCHEME_SELECT;
      sel_q1 <= sel_q0;
    end
  end

  wire req_high  = req_q[1];
  wire line_high = err_q[1];
  wire done_high = done_q[1];
  wire bit_rise  = bclk_q[1] & ~bclk_q[2];
  wire bit_val   = bdat_q[1];
  wire sch_fast  = (sel_q1 == `PSS_SCHEME_FAST);

  // ==========================================================
  // Two-entry byte buffer
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      buf_cnt;
  reg             run_busy;
  reg [WIDTH-1:0] run_val;

  wire buf_full  = (buf_cnt == DEPTH);
  wire buf_empty = (buf_cnt == {(AW+1){1'b0}});
  wire push      = run_busy & ~buf_full;
  wire pop       = ~buf_empty & CFG_BYTE_READY;

  assign CFG_BYTE       = mem[rd_ptr];
  assign CFG_BYTE_VALID = ~buf_empty;

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wr_ptr  <= {AW{1'b0}};
      rd_ptr  <= {AW{1'b0}};
      buf_cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (push & ~pop)
        buf_cnt <= buf_cnt + 1'b1;
      else if (pop & ~push)
        buf_cnt <= buf_cnt - 1'b1;
    end
  end

  // Storage needs no reset
  always @(posedge CLOCK) begin
    if (push) begin
      mem[wr_ptr] <= run_val;
    end
  end

  // ==========================================================
  // Control and bitstream reception
  reg [2:0]       state;
  reg [20:0]      cnt;
  reg [2:0]       bit_cnt;
  reg [7:0]       shift;
  reg             pair_phase;
  reg [7:0]       run_hold;
  reg [7:0]       run_left;
  reg [LEN_W-1:0] raw_cnt;

  wire [20:0] por_target = sch_fast ? POR_FAST_CYCLES
                                    : POR_STD_CYCLES;
  wire [7:0]  new_byte   = {bit_val, shift[7:1]};
  wire        len_met    = (raw_cnt == LOAD_LENGTH);
  wire        byte_in    = (state == ST_CONFIG) & bit_rise &
                           (bit_cnt == 3'h7) & ~len_met;

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state      <= ST_POR;
      cnt        <= 21'h0;
      bit_cnt    <= 3'h0;
      shift      <= 8'h0;
      pair_phase <= 1'b0;
      run_hold   <= 8'h0;
      run_left   <= 8'h0;
      run_busy   <= 1'b0;
      run_val    <= {WIDTH{1'b0}};
      raw_cnt    <= {LEN_W{1'b0}};
    end else begin
      // Expander feeds the buffer one byte per accepted push
      if (push) begin
        if (run_left == 8'h0)
          run_busy <= 1'b0;
        else
          run_left <= run_left - 8'h1;
      end
      case (state)
        ST_POR: begin
          cnt <= cnt + 21'h1;
          if (cnt == por_target - 21'h1) begin
            cnt   <= 21'h0;
            state <= ST_RESET;
          end
        end
        ST_RESET: begin
          cnt        <= 21'h0;
          bit_cnt    <= 3'h0;
          pair_phase <= 1'b0;
          run_busy   <= 1'b0;
          raw_cnt    <= {LEN_W{1'b0}};
          if (req_high & line_high)
            state <= ST_CONFIG;
        end
        ST_CONFIG: begin
          if (!req_high || !line_high) begin
            state <= ST_RESET;
          end else if (len_met & ~run_busy & ~pair_phase &
                       buf_empty & (LOAD_LENGTH != {LEN_W{1'b0}})) begin
            state <= ST_DONE;
          end else if (byte_in) begin
            raw_cnt <= raw_cnt + 1'b1;
            if (COMPRESSED & ~pair_phase) begin
              run_hold   <= new_byte;
              pair_phase <= 1'b1;
            end else if (run_busy) begin
              state <= ST_ERROR;
            end else begin
              run_val    <= new_byte[WIDTH-1:0];
              run_left   <= COMPRESSED ? run_hold : 8'h0;
              run_busy   <= 1'b1;
              pair_phase <= 1'b0;
            end
          end
          if (bit_rise) begin
            shift   <= new_byte;
            bit_cnt <= bit_cnt + 3'h1;
          end
        end
        ST_ERROR: begin
          run_busy <= 1'b0;
          if (AUTO_RESTART) begin
            cnt <= cnt + 21'h1;
            if (cnt == RESTART_CYCLES - 21'h1) begin
              cnt   <= 21'h0;
              state <= ST_RESET;
            end
          end else if (!req_high) begin
            state <= ST_RESET;
          end
        end
        ST_DONE: begin
          if (!req_high || !line_high)
            state <= ST_RESET;
          else if (done_high & INIT_DONE)
            state <= ST_USER;
        end
        ST_USER: begin
          if (!req_high)
            state <= ST_RESET;
        end
        default: begin
          state <= ST_RESET;
        end
      endcase
    end
  end

  // ==========================================================
  // Open-drain lines and user pin control
  assign CFG_ERROR_RESET_N_OUT = 1'b0;
  assign LOAD_COMPLETE_OUT     = 1'b0;

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      CFG_ERROR_RESET_N_OE_N <= `PSS_RST_OE_N;
      LOAD_COMPLETE_OE_N     <= `PSS_RST_OE_N;
      USER_IO_HIZ            <= `PSS_RST_HIZ;
      CFG_ERROR              <= 1'b0;
    end else begin
      CFG_ERROR_RESET_N_OE_N <= ~((state == ST_POR) |
                                  (state == ST_ERROR) |
                                  ((state == ST_RESET) &
                                   ~req_high));
      LOAD_COMPLETE_OE_N     <= (state == ST_DONE) |
                                (state == ST_USER);
      USER_IO_HIZ            <= (state != ST_USER);
      CFG_ERROR              <= (state == ST_ERROR);
    end
  end

endmodule

// [test/pss_config_slave_assertions.sv]
// Purpose: port checks for the configuration slave
// Assumes: bound to the top module, short power-on counts
// Notes:   open-drain lines are seen through their enables
`timescale 1ns/100ps
module pss_config_slave_assertions #(
  parameter [20:0] POR_FAST_CYCLES = 21'd20,
  parameter [20:0] RESTART_CYCLES  = 21'd16
) (
  input wire       CLOCK,
  input wire       RSTN,
  input wire       CFG_REQUEST_N,
  input wire       CFG_ERROR_RESET_N_OUT,
  input wire       CFG_ERROR_RESET_N_OE_N,
  input wire       LOAD_COMPLETE_OUT,
  input wire       LOAD_COMPLETE_OE_N,
  input wire       AUTO_RESTART,
  input wire       USER_IO_HIZ,
  input wire       CFG_ERROR,
  input wire [7:0] CFG_BYTE,
  input wire       CFG_BYTE_VALID,
  input wire       CFG_BYTE_READY
);
  localparam int RST_MAX = RESTART_CYCLES + 6;
  reg [7:0] por_cnt;
  // ==========================================================
  // Cycles since reset release, saturating
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      por_cnt <= 8'h00;
    else if (por_cnt != 8'hff)
      por_cnt <= por_cnt + 8'h01;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  a_drain_low: assert property (
    !CFG_ERROR_RESET_N_OUT && !LOAD_COMPLETE_OUT)
    else $error("Open-drain value not low");
  a_por_hold: assert property (
    por_cnt < POR_FAST_CYCLES |-> !CFG_ERROR_RESET_N_OE_N && USER_IO_HIZ)
    else $error("Status released during power-on delay");
  a_req_low: assert property (
    !CFG_REQUEST_N [*6] |->
      !CFG_ERROR_RESET_N_OE_N && !LOAD_COMPLETE_OE_N && USER_IO_HIZ)
    else $error("Request low not honoured");
  a_error_low: assert property (
    CFG_ERROR |-> !CFG_ERROR_RESET_N_OE_N && !LOAD_COMPLETE_OE_N)
    else $error("Error state with lines released");
  a_restart_bound: assert property (
    $rose(CFG_ERROR) && AUTO_RESTART |-> ##[1:RST_MAX] CFG_ERROR_RESET_N_OE_N)
    else $error("Auto restart too late");
  a_hiz_config: assert property (
    !LOAD_COMPLETE_OE_N |-> USER_IO_HIZ)
    else $error("User pins driven before load complete");
  a_byte_hold: assert property (
    CFG_BYTE_VALID && !CFG_BYTE_READY |=>
      (CFG_BYTE_VALID && $stable(CFG_BYTE)) or ##[0:1] CFG_ERROR)
    else $error("Stalled byte changed");
  a_done_clean: assert property (
    $rose(LOAD_COMPLETE_OE_N) |->
      CFG_ERROR_RESET_N_OE_N && !CFG_ERROR && !CFG_BYTE_VALID)
    else $error("Load complete with data pending");
  c_done: cover property ($rose(LOAD_COMPLETE_OE_N));
  c_restart: cover property ($rose(CFG_ERROR) && AUTO_RESTART);
  c_stall: cover property (CFG_BYTE_VALID && !CFG_BYTE_READY);
endmodule

// [test/pss_host_model.sv]
// Purpose: external host driving request, bit clock and data
// Assumes: 320 ns bit period, clock still between frames
// Notes:   data shows the inverse of its last bit once released
`timescale 1ns/100ps
module pss_host_model (
  output reg req_n,
  output reg bclk,
  output reg data
);
  initial begin
    req_n = 1'b1;
    bclk = 1'b0;
    data = 1'b0;
  end
  task set_req(input v);
    req_n = v;
  endtask
  task send_byte(input [7:0] b);
    integer i;
    #7;
    for (i = 0; i < 8; i = i + 1) begin
      data = b[i];
      #160 bclk = 1'b1;
      #160 bclk = 1'b0;
    end
    data = ~data;
  endtask
endmodule

// [test/pss_config_slave_bench.sv]
// Purpose: self-checking bench for the configuration slave
// Assumes: pull-ups on status and load-complete wires
// Notes:   expected bytes kept in a queue, popped per transfer
`timescale 1ns/100ps
module pss_config_slave_bench;
  reg        clock, rstn, auto_rs, comp, init_done, ready, rdy_rand, mon;
  reg  [3:0] scheme;
  reg [23:0] len;
  reg  [7:0] b, c;
  reg  [7:0] exp_q[$];
  wire       req_n, bclk, data, st_oe_n, ld_oe_n, hiz, err, vld;
  wire       st_out, ld_out, st_line, ld_line;
  wire [7:0] byte_q;
  integer    err_count, n_compared, cyc, i, k;
  pss_config_slave #(.POR_FAST_CYCLES(21'd20), .POR_STD_CYCLES(21'd40),
    .RESTART_CYCLES(21'd16)) i_dut (
    .CLOCK(clock), .RSTN(rstn), .SCHEME_SELECT(scheme),
    .CFG_REQUEST_N(req_n), .CFG_ERROR_RESET_N_IN(st_line),
    .CFG_ERROR_RESET_N_OUT(st_out), .CFG_ERROR_RESET_N_OE_N(st_oe_n),
    .LOAD_COMPLETE_IN(ld_line), .LOAD_COMPLETE_OUT(ld_out),
    .LOAD_COMPLETE_OE_N(ld_oe_n), .CFG_BIT_CLOCK(bclk), .CFG_DATA(data),
    .AUTO_RESTART(auto_rs), .COMPRESSED(comp), .LOAD_LENGTH(len),
    .INIT_DONE(init_done), .USER_IO_HIZ(hiz), .CFG_ERROR(err),
    .CFG_BYTE(byte_q), .CFG_BYTE_VALID(vld), .CFG_BYTE_READY(ready));
  pss_host_model host (.req_n(req_n), .bclk(bclk), .data(data));
  // Pull-ups win only while the device releases its line
  assign st_line = st_oe_n ? 1'b1 : st_out;
  assign ld_line = ld_oe_n ? 1'b1 : ld_out;
  always #20 clock = ~clock;
  // ==========================================================
  // Checking helpers
  task chk(input [31:0] got, input [31:0] want);
    n_compared = n_compared + 1;
    if (got !== want) begin
      err_count = err_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task wait_hi(input integer w);
    cyc = 0;
    while ((w == 0 ? st_oe_n : w == 1 ? ld_oe_n : err) !== 1'b1
           && cyc < 3000) begin
      @(negedge clock);
      cyc = cyc + 1;
    end
  endtask
  task restart;
    host.set_req(1'b0);
    repeat (15) @(negedge clock);
    chk({st_oe_n, ld_oe_n, hiz}, 3'b001);
    chk({st_line, ld_line, st_out, ld_out}, 4'h0);
    init_done = 1'b0;
    host.set_req(1'b1);
    wait_hi(0);
    chk(cyc < 8, 1);
  endtask
  task load(input c_on, input [23:0] n);
    comp = c_on;
    len = n;
    for (k = 0; k < n; k = k + 2) begin
      c = c_on ? $urandom % 3 : $urandom;
      b = $urandom;
      if (!c_on)
        exp_q.push_back(c);
      repeat (c_on ? c + 1 : 1) exp_q.push_back(b);
      host.send_byte(c);
      host.send_byte(b);
    end
  endtask
  task conclude;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Consumer and reference comparison
  always @(negedge clock)
    if (rdy_rand)
      ready <= $urandom % 2;
  always @(posedge clock)
    if (mon && vld && ready) begin
      if (exp_q.size() == 0)
        chk(byte_q, 32'h100);
      else
        chk(byte_q, exp_q.pop_front());
    end
  initial begin
    #2000000;
    err_count = err_count + 1;
    conclude();
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(37));
    clock = 1'b0;
    rstn = 1'b0;
    auto_rs = 1'b0;
    comp = 1'b0;
    len = 24'h0;
    init_done = 1'b0;
    ready = 1'b1;
    rdy_rand = 1'b0;
    mon = 1'b1;
    err_count = 0;
    n_compared = 0;
    for (i = 0; i < 2; i = i + 1) begin
      rstn = 1'b0;
      scheme = i ? 4'h0 : 4'hc;
      repeat (4) @(negedge clock);
      chk({st_oe_n, hiz}, 2'b01);
      rstn = 1'b1;
      wait_hi(0);
      chk(cyc > (i ? 40 : 20) && cyc < (i ? 52 : 32), 1);
    end
    rdy_rand = 1'b1;
    host.set_req(1'b0);
    host.send_byte(8'h5a);
    restart();
    load(1'b0, 24'd4);
    wait_hi(1);
    chk({hiz, exp_q.size() == 0}, 2'b11);
    init_done = 1'b1;
    repeat (8) @(negedge clock);
    chk(hiz, 0);
    restart();
    load(1'b1, 24'd4);
    wait_hi(1);
    chk(exp_q.size(), 0);
    chk(ld_line, 1);
    if (ld_line !== 1'b1)
      restart();
    restart();
    rdy_rand = 1'b0;
    ready = 1'b0;
    auto_rs = 1'b1;
    mon = 1'b0;
    comp = 1'b0;
    len = 24'd8;
    for (k = 0; k < 4; k = k + 1)
      host.send_byte($urandom);
    wait_hi(2);
    chk(err, 1);
    wait_hi(0);
    chk(cyc <= 22, 1);
    conclude();
  end
endmodule
bind pss_config_slave pss_config_slave_assertions #(
  .POR_FAST_CYCLES(POR_FAST_CYCLES), .RESTART_CYCLES(RESTART_CYCLES)) i_chk (
  .CLOCK(CLOCK), .RSTN(RSTN), .CFG_REQUEST_N(CFG_REQUEST_N),
  .CFG_ERROR_RESET_N_OUT(CFG_ERROR_RESET_N_OUT),
  .CFG_ERROR_RESET_N_OE_N(CFG_ERROR_RESET_N_OE_N),
  .LOAD_COMPLETE_OUT(LOAD_COMPLETE_OUT),
  .LOAD_COMPLETE_OE_N(LOAD_COMPLETE_OE_N), .AUTO_RESTART(AUTO_RESTART),
  .USER_IO_HIZ(USER_IO_HIZ), .CFG_ERROR(CFG_ERROR), .CFG_BYTE(CFG_BYTE),
  .CFG_BYTE_VALID(CFG_BYTE_VALID), .CFG_BYTE_READY(CFG_BYTE_READY));
